// *** verilog/synth_ctrl_pkg.sv ***
// shared constants, field layouts and carriers for the synthesizer control block
package synth_ctrl_pkg;
  // ---------------------------------------------------------------
  // serial frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS = 4;
  localparam int WORD_BITS = 12;
  localparam int CNT_BITS = 5;
  localparam int SAMPLE_MIN_BITS = 2;
  localparam int SAMPLE_MAX_BITS = 12;
  localparam logic [CNT_BITS-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_BITS-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_BITS-1:0] CNT_MIN = 5'h02;
  localparam logic [CNT_BITS-1:0] CNT_MAX = 5'h0c;
  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [ADDR_BITS-1:0] ADDR_PD_SEL = 4'h7;
  localparam logic [ADDR_BITS-1:0] ADDR_MOD_CTRL = 4'h8;
  localparam logic [ADDR_BITS-1:0] ADDR_MOD_SAMPLE = 4'h9;
  // ---------------------------------------------------------------
  // output select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_REF_OSC = 3'h0;
  localparam logic [2:0] SEL_AUX_REF = 3'h1;
  localparam logic [2:0] SEL_MAIN_REF = 3'h2;
  localparam logic [2:0] SEL_AUX_CMP = 3'h3;
  localparam logic [2:0] SEL_MAIN_CMP = 3'h4;
  localparam logic [2:0] SEL_SER_OUT = 3'h5;
  localparam logic [2:0] SEL_SER_TEST = 3'h6;
  // ---------------------------------------------------------------
  // modulation scaling
  // ---------------------------------------------------------------
  localparam logic [3:0] MAG_MAX = 4'hd;
  localparam int OFFSET_BITS = WORD_BITS + 13;
  localparam logic [4:0] FRAC_BITS_WIDE = 5'h12;
  localparam logic [4:0] FRAC_BITS_NARROW = 5'h0a;
  localparam logic [18:0] STEP_DIV_WIDE = 19'h4_0000;
  localparam logic [18:0] STEP_DIV_NARROW = 19'h0_0400;
  // ---------------------------------------------------------------
  // register fields
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] spare;
    logic tristate;
    logic [2:0] out_sel;
    logic aux_integer;
    logic aux_power_down;
    logic frac_ten_bit;
    logic main_integer;
    logic main_power_down;
    logic full_power_down;
  } pd_ctrl_s;
  typedef struct packed {
    logic [5:0] spare;
    logic addr_disable;
    logic input_select;
    logic [3:0] magnitude;
  } mod_ctrl_s;
  localparam pd_ctrl_s PD_CTRL_RESET = 12'h000;
  localparam mod_ctrl_s MOD_CTRL_RESET = 12'h000;
endpackage

// *** verilog/synth_output_select_and_modulation.sv ***
// output select, power-down flags and modulation unit behind the three-wire port
`timescale 1ns/1ps
module synth_output_select_and_modulation #(
  parameter int BUF_DEPTH = 2,
  parameter int BUF_WIDTH = synth_ctrl_pkg::WORD_BITS
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic serial_clock_in,
  input wire logic select_n_in,
  input wire logic serial_data_in,
  input wire logic alt_sample_in,
  input wire logic ref_osc_in,
  input wire logic aux_divided_ref_in,
  input wire logic main_divided_ref_in,
  input wire logic aux_compare_frequency_in,
  input wire logic main_compare_frequency_in,
  output logic test_pin_out,
  output logic test_pin_oe_out,
  output logic aux_power_down_out,
  output logic aux_integer_out,
  output logic main_power_down_out,
  output logic main_integer_out,
  output logic full_power_down_out,
  output logic [4:0] main_frac_bits_out,
  output logic [18:0] main_step_divisor_out,
  output logic signed [synth_ctrl_pkg::OFFSET_BITS-1:0] mod_offset_out,
  output logic sample_ready_out
);
  import synth_ctrl_pkg::*;

  // ---------------------------------------------------------------
  // link side: serial clock domain
  // ---------------------------------------------------------------
  logic in_frame_reg;
  logic [FRAME_BITS-1:0] shift_reg;
  logic [FRAME_BITS-1:0] alt_shift_reg;
  logic [CNT_BITS-1:0] count_reg;
  pd_ctrl_s pd_ctrl_reg;
  mod_ctrl_s mod_ctrl_reg;

  // both pins shift side by side; the pin choice is made after the frame in the
  // main clock, since the idle link clock could never settle a synchroniser

  // select high ends the frame; the flag is cleared without the link clock,
  // which is idle between frames, while shift and count stay for the reader
  always_ff @(posedge serial_clock_in or posedge select_n_in) begin
    if (select_n_in) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= 1'b1;
    end
  end

  always_ff @(posedge serial_clock_in) begin
    if (!select_n_in) begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], serial_data_in};
      alt_shift_reg <= {alt_shift_reg[FRAME_BITS-2:0], alt_sample_in};
      if (!in_frame_reg) begin
        count_reg <= CNT_ONE;
      end else if (count_reg != CNT_FULL + CNT_ONE) begin
        count_reg <= count_reg + CNT_ONE;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers into the main clock
  // ---------------------------------------------------------------
  localparam int NPINS = 7;
  logic [NPINS-1:0] pin_raw;
  logic [NPINS-1:0] pin_meta_reg;
  logic [NPINS-1:0] pin_sync_reg;
  logic sel_last_reg;
  logic cmp_last_reg;

  assign pin_raw = {select_n_in, serial_data_in, main_compare_frequency_in,
                    aux_compare_frequency_in, main_divided_ref_in,
                    aux_divided_ref_in, ref_osc_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_sync
      always_ff @(posedge clock_in) begin
        // only select idles high; the rest reset low so no false edge follows
        if (reset_in) begin
          pin_meta_reg[gi] <= (gi == 6);
          pin_sync_reg[gi] <= (gi == 6);
        end else begin
          pin_meta_reg[gi] <= pin_raw[gi];
          pin_sync_reg[gi] <= pin_meta_reg[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sel_last_reg <= 1'b1;
    end else begin
      sel_last_reg <= pin_sync_reg[6];
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cmp_last_reg <= 1'b0;
    end else begin
      cmp_last_reg <= pin_sync_reg[4];
    end
  end

  logic frame_done;
  logic cmp_fall;
  assign frame_done = pin_sync_reg[6] & ~sel_last_reg;
  assign cmp_fall = ~pin_sync_reg[4] & cmp_last_reg;

  // ---------------------------------------------------------------
  // frame decode
  // ---------------------------------------------------------------
  logic [ADDR_BITS-1:0] frame_addr;
  logic [WORD_BITS-1:0] frame_word;
  logic [WORD_BITS-1:0] sample_word;
  logic short_frame;
  logic long_frame;
  logic [WORD_BITS-1:0] short_sample;
  logic push_valid;
  logic [WORD_BITS-1:0] push_data;
  logic [3:0] pad;

  assign frame_addr = shift_reg[FRAME_BITS-1 -: ADDR_BITS];
  assign frame_word = shift_reg[WORD_BITS-1:0];
  assign short_frame = mod_ctrl_reg.addr_disable && count_reg >= CNT_MIN &&
                       count_reg <= CNT_MAX;
  assign long_frame = !mod_ctrl_reg.addr_disable && count_reg == CNT_FULL;
  assign pad = 4'(CNT_MAX - count_reg);
  // addressed frames always use the data pin; only bare samples may use the other
  assign sample_word = mod_ctrl_reg.input_select ?
                       alt_shift_reg[WORD_BITS-1:0] : frame_word;
  // left-justify then arithmetic shift back: sign bit fills the top
  assign short_sample = WORD_BITS'($signed(sample_word << pad) >>> pad);

  always_comb begin
    push_valid = 1'b0;
    push_data = frame_word;
    if (frame_done && short_frame) begin
      push_valid = 1'b1;
      push_data = short_sample;
    end else if (frame_done && long_frame && frame_addr == ADDR_MOD_SAMPLE) begin
      push_valid = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pd_ctrl_reg <= PD_CTRL_RESET;
    end else if (frame_done && long_frame && frame_addr == ADDR_PD_SEL) begin
      pd_ctrl_reg <= frame_word;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mod_ctrl_reg <= MOD_CTRL_RESET;
    end else if (frame_done && long_frame && frame_addr == ADDR_MOD_CTRL) begin
      mod_ctrl_reg <= frame_word;
    end
  end

  // ---------------------------------------------------------------
  // sample buffer
  // ---------------------------------------------------------------
  localparam int PW = $clog2(BUF_DEPTH);
  logic [BUF_WIDTH-1:0] buf_mem [BUF_DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] fill_reg;
  logic buf_ready;
  logic buf_valid;
  logic pop;
  logic push;

  // the host cannot be stalled; a sample sent while full is dropped
  assign buf_ready = fill_reg != (PW+1)'(BUF_DEPTH);
  assign buf_valid = fill_reg != '0;
  assign push = push_valid & buf_ready;
  assign sample_ready_out = buf_ready;

  always_ff @(posedge clock_in) begin
    if (push) begin
      buf_mem[wr_ptr_reg] <= push_data;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fill_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(BUF_DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(BUF_DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      fill_reg <= fill_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // ---------------------------------------------------------------
  // modulation unit
  // ---------------------------------------------------------------
  logic unit_full_reg;
  logic signed [WORD_BITS-1:0] unit_sample_reg;
  logic [3:0] mag;
  logic signed [OFFSET_BITS-1:0] scaled;

  // the unit accepts only on a compare fall, so the buffer stalls between
  assign pop = cmp_fall & buf_valid;
  // out-of-range magnitudes clamp to the largest valid shift
  assign mag = (mod_ctrl_reg.magnitude > MAG_MAX) ? MAG_MAX : mod_ctrl_reg.magnitude;
  assign scaled = OFFSET_BITS'(unit_sample_reg) <<< mag;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      unit_sample_reg <= '0;
      unit_full_reg <= 1'b0;
    end else if (cmp_fall) begin
      unit_full_reg <= pop;
      if (pop) begin
        unit_sample_reg <= $signed(buf_mem[rd_ptr_reg]);
      end
    end
  end

  // applied one compare fall after entry; the offset then holds
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mod_offset_out <= '0;
    end else if (cmp_fall && unit_full_reg) begin
      mod_offset_out <= scaled;
    end
  end

  // ---------------------------------------------------------------
  // flags and test pin
  // ---------------------------------------------------------------
  logic test_next;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      aux_power_down_out <= 1'b0;
    end else begin
      aux_power_down_out <= pd_ctrl_reg.aux_power_down;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      aux_integer_out <= 1'b0;
    end else begin
      aux_integer_out <= pd_ctrl_reg.aux_integer;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      main_power_down_out <= 1'b0;
    end else begin
      main_power_down_out <= pd_ctrl_reg.main_power_down;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      main_integer_out <= 1'b0;
    end else begin
      main_integer_out <= pd_ctrl_reg.main_integer;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      full_power_down_out <= 1'b0;
    end else begin
      full_power_down_out <= pd_ctrl_reg.full_power_down;
    end
  end

  // the narrow modulator saves power at the cost of a coarser step
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      main_frac_bits_out <= FRAC_BITS_WIDE;
      main_step_divisor_out <= STEP_DIV_WIDE;
    end else if (pd_ctrl_reg.frac_ten_bit) begin
      main_frac_bits_out <= FRAC_BITS_NARROW;
      main_step_divisor_out <= STEP_DIV_NARROW;
    end else begin
      main_frac_bits_out <= FRAC_BITS_WIDE;
      main_step_divisor_out <= STEP_DIV_WIDE;
    end
  end

  always_comb begin
    case (pd_ctrl_reg.out_sel)
      SEL_REF_OSC: test_next = pin_sync_reg[0];
      SEL_AUX_REF: test_next = pin_sync_reg[1];
      SEL_MAIN_REF: test_next = pin_sync_reg[2];
      SEL_AUX_CMP: test_next = pin_sync_reg[3];
      SEL_MAIN_CMP: test_next = pin_sync_reg[4];
      SEL_SER_OUT: test_next = pin_sync_reg[5];
      SEL_SER_TEST: test_next = frame_done;
      default: test_next = 1'b0;
    endcase
  end

  // the pin lags its source by three clocks; fine for observation only
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      test_pin_out <= 1'b0;
    end else begin
      test_pin_out <= test_next;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      test_pin_oe_out <= 1'b1;
    end else begin
      test_pin_oe_out <= ~pd_ctrl_reg.tristate;
    end
  end
endmodule // synth_output_select_and_modulation

// *** testbench/synth_chk.sv ***
// assertion checker for the output select and modulation block
`timescale 1ns/1ps
module synth_chk (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic select_n_in,
  input wire logic main_compare_frequency_in,
  input wire logic test_pin_oe_out,
  input wire logic aux_power_down_out,
  input wire logic aux_integer_out,
  input wire logic [4:0] main_frac_bits_out,
  input wire logic [18:0] main_step_divisor_out,
  input wire logic signed [synth_ctrl_pkg::OFFSET_BITS-1:0] mod_offset_out,
  input wire logic sample_ready_out
);
  import synth_ctrl_pkg::*;
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  logic [3:0] fall_age_reg;
  // saturates so a long quiet spell never wraps back into the window
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      fall_age_reg <= 4'hf;
    end else if ($fell(main_compare_frequency_in)) begin
      fall_age_reg <= 4'h0;
    end else if (fall_age_reg != 4'hf) begin
      fall_age_reg <= fall_age_reg + 4'h1;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // a frame is only acted on well after select returns high
  sequence held3(sig);
    $stable(sig) [*3];
  endsequence
  chk_reset_flags: assert property (
    $fell(reset_in) |-> test_pin_oe_out && !aux_power_down_out && !aux_integer_out)
    else $error("flags not at reset values");
  chk_reset_offset: assert property (
    $fell(reset_in) |-> mod_offset_out == 25'h0 && sample_ready_out)
    else $error("offset or ready not at reset values");
  chk_width_pairs: assert property (
    main_frac_bits_out == 5'h12 ? main_step_divisor_out == 19'h4_0000
    : (main_frac_bits_out == 5'h0a && main_step_divisor_out == 19'h0_0400))
    else $error("width and step divisor disagree");
  chk_auxpd_quiet: assert property (!select_n_in |=> held3(aux_power_down_out))
    else $error("aux power-down moved during a frame");
  chk_auxint_quiet: assert property (!select_n_in |=> held3(aux_integer_out))
    else $error("aux mode moved during a frame");
  chk_frac_quiet: assert property (!select_n_in |=> held3(main_frac_bits_out))
    else $error("width moved during a frame");
  chk_oe_quiet: assert property (!select_n_in |=> held3(test_pin_oe_out))
    else $error("pin enable moved during a frame");
  chk_offset_fall: assert property (
    $changed(mod_offset_out) |-> fall_age_reg inside {[4'h1:4'h6]})
    else $error("offset changed away from a compare fall");
endmodule // synth_chk
bind synth_output_select_and_modulation synth_chk u_chk (
  .clock_in(clock_in), .reset_in(reset_in), .select_n_in(select_n_in),
  .main_compare_frequency_in(main_compare_frequency_in),
  .test_pin_oe_out(test_pin_oe_out), .aux_power_down_out(aux_power_down_out),
  .aux_integer_out(aux_integer_out), .main_frac_bits_out(main_frac_bits_out),
  .main_step_divisor_out(main_step_divisor_out), .mod_offset_out(mod_offset_out),
  .sample_ready_out(sample_ready_out)
);

// *** testbench/host_model.sv ***
// host controller model driving the three-wire serial port
`timescale 1ns/1ps
module host_model (
  output logic serial_clock_out,
  output logic select_n_out,
  output logic data_out,
  output logic alt_out
);
  initial begin
    serial_clock_out = 1'b0;
    select_n_out = 1'b1;
    data_out = 1'b0;
    alt_out = 1'b1;
  end
  // link clock stands still between frames
  task automatic send(input logic [15:0] word, input int n, input logic on_alt);
    #37;
    select_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      data_out = on_alt ? ~word[i] : word[i];
      alt_out = on_alt ? word[i] : ~word[i];
      #80;
      serial_clock_out = 1'b1;
      #80;
      serial_clock_out = 1'b0;
    end
    #80;
    select_n_out = 1'b1;
    // released lines flip so a stale bit never reads as data
    data_out = ~data_out;
    alt_out = ~alt_out;
    #400;
  endtask
endmodule // host_model

// *** testbench/testbench.sv ***
// self-checking bench for the output select and modulation block
`timescale 1ns/1ps
module testbench;
  import synth_ctrl_pkg::*;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [4:0] src = 5'h00;
  logic sclk, sel_n, sdata, salt, pin, oe, aux_pd, aux_int, ready, main_pd, main_int, full_pd;
  logic [4:0] frac;
  logic [18:0] divisor;
  logic signed [24:0] offset;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  always #20 clock_in = ~clock_in;
  host_model u_host (.serial_clock_out(sclk), .select_n_out(sel_n), .data_out(sdata),
    .alt_out(salt));
  synth_output_select_and_modulation u_dut (.clock_in(clock_in), .reset_in(reset_in),
    .serial_clock_in(sclk), .select_n_in(sel_n), .serial_data_in(sdata),
    .alt_sample_in(salt), .ref_osc_in(src[0]), .aux_divided_ref_in(src[1]),
    .main_divided_ref_in(src[2]), .aux_compare_frequency_in(src[3]),
    .main_compare_frequency_in(src[4]), .test_pin_out(pin), .test_pin_oe_out(oe),
    .aux_power_down_out(aux_pd), .aux_integer_out(aux_int), .main_power_down_out(main_pd),
    .main_integer_out(main_int), .full_power_down_out(full_pd), .main_frac_bits_out(frac),
    .main_step_divisor_out(divisor), .mod_offset_out(offset), .sample_ready_out(ready));
  task automatic wrap_up();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check_val(input logic [24:0] got, input logic [24:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic write_reg(input logic [3:0] addr, input logic [11:0] data);
    u_host.send({addr, data}, 16, 1'b0);
    tick(2);
  endtask
  task automatic cmp_fall();
    src[4] <= 1'b1;
    tick(6);
    src[4] <= 1'b0;
    tick(6);
  endtask
  // low n bits of s, sign-extended, then scaled by two to the m
  function automatic logic [24:0] exp_offset(input logic [11:0] s, input int n, input int m);
    logic signed [24:0] v;
    v = signed'({s << (12 - n), 13'h0000}) >>> (25 - n);
    return v <<< m;
  endfunction
  // ceiling far above the few thousand cycles the sequence needs
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [11:0] w, s, s2;
    logic [24:0] e;
    int n, m;
    void'($urandom(32'h8e29_0d59));
    tick(4);
    reset_in <= 1'b0;
    tick(2);
    check_val(25'(oe), 25'h1);
    check_val(25'({aux_pd, aux_int, main_pd, main_int, full_pd}), 25'h0);
    check_val(25'(frac), 25'h0_0012);
    for (int i = 0; i < 6; i++) begin
      w = 12'($urandom());
      w[3] = i[0];
      write_reg(4'h7, w);
      check_val(25'(aux_pd), 25'(w[4]));
      check_val(25'(aux_int), 25'(w[5]));
      check_val(25'({full_pd, main_pd, main_int}), 25'({w[0], w[1], w[2]}));
      check_val(25'(oe), 25'(!w[9]));
      check_val(25'(frac), w[3] ? 25'h0_000a : 25'h0_0012);
      check_val(25'(divisor), w[3] ? 25'h0_0400 : 25'h4_0000);
    end
    for (int c = 0; c < 8; c++) begin
      write_reg(4'h7, {3'h0, c[2:0], 6'h00});
      src <= 5'h01 << c;
      tick(8);
      check_val(25'(pin), 25'((c < 5) || (c == 5 && sdata)));
      src <= ~(5'h01 << c);
      tick(8);
      check_val(25'(pin), 25'(c == 5 && sdata));
    end
    src <= 5'h00;
    e = 25'h0;
    for (int i = 0; i < 4; i++) begin
      m = (i == 0) ? 13 : $urandom_range(12);
      s = (i == 1) ? 12'h800 : 12'($urandom());
      write_reg(4'h8, 12'(m));
      write_reg(4'h9, s);
      cmp_fall();
      check_val(offset, e);
      cmp_fall();
      e = exp_offset(s, 12, m);
      check_val(offset, e);
    end
    for (int p = 0; p < 2; p++) begin
      m = $urandom_range(13);
      write_reg(4'h8, {6'h00, 1'b1, p[0], m[3:0]});
      for (int i = 0; i < 4; i++) begin
        n = (i == 0) ? 2 : (i == 1) ? 12 : $urandom_range(12, 2);
        s = 12'($urandom());
        u_host.send(16'(s), n, p[0]);
        tick(2);
        cmp_fall();
        cmp_fall();
        check_val(offset, exp_offset(s, n, m));
      end
      s = 12'($urandom());
      s2 = 12'($urandom());
      u_host.send(16'(s), 12, p[0]);
      u_host.send(16'(s2), 12, p[0]);
      tick(2);
      check_val(25'(ready), 25'h0);
      // full buffer drops this one, so the last offset must come from s2
      u_host.send(16'(~s2), 12, p[0]);
      tick(2);
      repeat (4) cmp_fall();
      check_val(offset, exp_offset(s2, 12, m));
      check_val(25'(ready), 25'h1);
      reset_in <= 1'b1;
      tick(4);
      reset_in <= 1'b0;
      tick(2);
      check_val(offset, 25'h0);
    end
    wrap_up();
  end
endmodule // testbench
